//--- rtl/hpi_top.sv
// Host port slave: host pins to on-chip memory DMA, keepers, control
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "hpi_params.svh"
module hpi_top
  import hpi_pkg::*;
(
  input  wire logic                CORE_CLK_I,
  input  wire logic                RST_I,
  input  wire logic                WIDE_HOST_STRAP_I,
  input  wire logic                HOST_CHIP_SELECT_N_I,
  input  wire logic                HOST_STROBE_ONE_N_I,
  input  wire logic                HOST_STROBE_TWO_N_I,
  input  wire logic                HOST_READ_WRITE_I,
  input  wire logic                BYTE_HALF_SELECT_I,
  input  wire logic [1:0]          HOST_REG_SELECT_I,
  input  wire logic [`HPI_AW-1:0]  HOST_ADDRESS_BUS_I,
  input  wire logic [`HPI_DW-1:0]  HOST_DATA_BUS_I,
  output logic      [`HPI_DW-1:0]  HOST_DATA_BUS_O,
  output logic                     HOST_DATA_BUS_OE_O,
  output logic                     HOST_READY_OUT_O,
  output logic                     HOST_INT_N_O,
  output logic                     CPU_INT_O,
  input  wire logic [`HPI_RAW-1:0] REG_ADDR_I,
  input  wire logic [`HPI_DW-1:0]  REG_WDATA_I,
  input  wire logic                REG_WR_I,
  input  wire logic                REG_RD_I,
  output logic      [`HPI_DW-1:0]  REG_RDATA_O,
  output logic                     DMA_REQ_O,
  output logic                     DMA_WE_O,
  output logic      [`HPI_AW-1:0]  DMA_ADDR_O,
  output logic      [`HPI_DW-1:0]  DMA_WDATA_O,
  input  wire logic [`HPI_DW-1:0]  DMA_RDATA_I,
  input  wire logic                DMA_ACK_I,
  input  wire logic                CPU_MEM_REQ_I,
  input  wire logic [`HPI_AW-1:0]  CPU_MEM_ADDR_I,
  output logic                     CPU_WAIT_O,
  output logic                     DATA_KEEPER_O,
  output logic                     HOST_KEEPER_O,
  output logic                     ADDR_KEEPER_O
);

  hpi_state_s s_q;
  hpi_state_s s_d;

  // ----------------------------------------
  // Synchronised pin fields
  // ----------------------------------------
  logic                wide;
  logic                stb;
  logic                rd;
  logic                half;
  logic [1:0]          sel;
  logic [`HPI_AW-1:0]  pa;
  logic [`HPI_DW-1:0]  pd;
  logic                rise;
  logic [`HPI_DW-1:0]  ctl_word;

  // Only the second stage is decoded
  // strap selects width
  assign wide     = s_q.pin2[`HPI_PIN_STRAP];
  assign stb      = ~s_q.pin2[`HPI_PIN_CSN]
                    & (~s_q.pin2[`HPI_PIN_STB1N] | ~s_q.pin2[`HPI_PIN_STB2N]);
  assign rd       = s_q.pin2[`HPI_PIN_RW];
  assign half     = s_q.pin2[`HPI_PIN_HALF];
  assign sel      = s_q.pin2[`HPI_PIN_SEL];
  assign pa       = s_q.pin2[`HPI_PIN_ADR];
  assign pd       = s_q.pin2[`HPI_PIN_DAT];
  assign rise     = stb & ~s_q.stb_prev;
  assign ctl_word = {14'h0000, s_q.host_int, s_q.dsp_int};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pin1 = {WIDE_HOST_STRAP_I, HOST_CHIP_SELECT_N_I, HOST_STROBE_ONE_N_I,
                HOST_STROBE_TWO_N_I, HOST_READ_WRITE_I, BYTE_HALF_SELECT_I,
                HOST_REG_SELECT_I, HOST_ADDRESS_BUS_I, HOST_DATA_BUS_I};
    s_d.pin2 = s_q.pin1;
    s_d.stb_prev = stb;
    s_d.rdata = '0;
    if (REG_WR_I && REG_ADDR_I == `HPI_RA_CTL && REG_WDATA_I[`HPI_CTL_DSPI]) begin
      s_d.dsp_int = 1'b0;
    end
    // Host side sequencer
    case (s_q.state)
      HPI_IDLE: begin
        s_d.ready = 1'b1;
        s_d.oe = 1'b0;
        if (rise) begin
          if (wide) begin
            s_d.addr = pa;
            s_d.data = pd;
            s_d.dma_we = ~rd;
            s_d.dma_req = 1'b1;
            s_d.ready = 1'b0;
            s_d.inc = 1'b0;
            s_d.state = HPI_DMA;
          end else if (sel == `HPI_SEL_CTL) begin
            s_d.state = HPI_DONE;
            if (rd) begin
              s_d.hout = ctl_word;
              s_d.oe = 1'b1;
            end else if (half) begin
              if (pd[`HPI_CTL_DSPI]) begin
                s_d.dsp_int = 1'b1;
              end
              if (pd[`HPI_CTL_HSTI]) begin
                s_d.host_int = 1'b0;
              end
            end
          end else if (sel == `HPI_SEL_ADR) begin
            s_d.state = HPI_DONE;
            if (rd) begin
              s_d.hout = {8'h00, half ? s_q.addr[7:0] : s_q.addr[15:8]};
              s_d.oe = 1'b1;
            end else if (half) begin
              s_d.addr[7:0] = pd[7:0];
            end else begin
              s_d.addr[15:8] = pd[7:0];
            end
          end else begin
            s_d.inc = (sel == `HPI_SEL_DINC);
            s_d.state = HPI_DONE;
            if (rd && !half) begin
              s_d.dma_we = 1'b0;
              s_d.dma_req = 1'b1;
              s_d.ready = 1'b0;
              s_d.state = HPI_DMA;
            end else if (rd) begin
              s_d.hout = {8'h00, s_q.data[7:0]};
              s_d.oe = 1'b1;
              if (sel == `HPI_SEL_DINC) begin
                s_d.addr = s_q.addr + `HPI_ADR_INC;
              end
            end else if (!half) begin
              s_d.latch = pd[7:0];
            end else begin
              s_d.data = {s_q.latch, pd[7:0]};
              s_d.dma_we = 1'b1;
              s_d.dma_req = 1'b1;
              s_d.ready = 1'b0;
              s_d.state = HPI_DMA;
            end
          end
        end
      end
      HPI_DMA: begin
        // wait on DMA until DMA_ACK_I
        if (DMA_ACK_I) begin
          s_d.dma_req = 1'b0;
          s_d.ready = 1'b1;
          s_d.state = HPI_DONE;
          if (!s_q.dma_we) begin
            s_d.data = DMA_RDATA_I;
            s_d.hout = wide ? DMA_RDATA_I : {8'h00, DMA_RDATA_I[15:8]};
            s_d.oe = 1'b1;
          end else if (s_q.inc) begin
            s_d.addr = s_q.addr + `HPI_ADR_INC;
          end
        end
      end
      default: begin
        if (!stb) begin
          s_d.oe = 1'b0;
          s_d.state = HPI_IDLE;
        end
      end
    endcase
    // Processor register port
    if (REG_WR_I) begin
      if (REG_ADDR_I == `HPI_RA_CTL) begin
        if (REG_WDATA_I[`HPI_CTL_HSTI]) begin
          s_d.host_int = 1'b1;
        end
      end else if (REG_ADDR_I == `HPI_RA_BSC) begin
        s_d.bh = REG_WDATA_I[`HPI_BSC_BH];
        s_d.host_keeper_enable = REG_WDATA_I[`HPI_BSC_HBH];
      end
    end
    if (REG_RD_I) begin
      if (REG_ADDR_I == `HPI_RA_CTL) begin
        s_d.rdata = ctl_word;
      end else if (REG_ADDR_I == `HPI_RA_BSC) begin
        s_d.rdata = '0;
        s_d.rdata[`HPI_BSC_BH] = s_q.bh;
        s_d.rdata[`HPI_BSC_HBH] = s_q.host_keeper_enable;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // keeper bits clear at reset
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_q <= '{pin1: '1, pin2: '1, state: HPI_IDLE, ready: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign HOST_DATA_BUS_O    = s_q.hout;
  assign HOST_DATA_BUS_OE_O = s_q.oe;
  assign HOST_READY_OUT_O   = s_q.ready;
  assign HOST_INT_N_O       = ~s_q.host_int;
  assign CPU_INT_O          = s_q.dsp_int;
  assign REG_RDATA_O        = s_q.rdata;
  assign DMA_REQ_O          = s_q.dma_req;
  assign DMA_WE_O           = s_q.dma_we;
  assign DMA_ADDR_O         = s_q.addr;
  assign DMA_WDATA_O        = s_q.data;
  // processor held while host owns word
  assign CPU_WAIT_O    = CPU_MEM_REQ_I & s_q.dma_req & (CPU_MEM_ADDR_I == s_q.addr);
  assign DATA_KEEPER_O = s_q.bh;
  assign HOST_KEEPER_O = s_q.host_keeper_enable | wide;
  assign ADDR_KEEPER_O = s_q.host_keeper_enable & wide;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_launch;
    rise && wide && s_q.state == HPI_IDLE;
  endsequence
  sequence s_ack;
    s_q.state == HPI_DMA && DMA_ACK_I;
  endsequence
  sequence s_ctl_wr;
    rise && !wide && !rd && half && sel == `HPI_SEL_CTL && s_q.state == HPI_IDLE;
  endsequence

  wide_launch_a: assert property (s_launch |=> DMA_REQ_O && !HOST_READY_OUT_O)
    else $error("wide access did not launch DMA");
  wide_addr_a: assert property (s_launch |=> DMA_ADDR_O == $past(pa))
    else $error("wide address not taken from pins");
  ready_hold_a: assert property (DMA_REQ_O |-> !HOST_READY_OUT_O)
    else $error("ready high while DMA pending");
  ack_ready_a: assert property (s_ack |=> HOST_READY_OUT_O && !DMA_REQ_O)
    else $error("ready not restored after DMA");
  seq_inc_a: assert property (s_ack ##0 (DMA_WE_O && s_q.inc)
                              |=> DMA_ADDR_O == $past(DMA_ADDR_O) + `HPI_ADR_INC)
    else $error("address did not increment");
  sync_lat_a: assert property ($fell(HOST_CHIP_SELECT_N_I) ##1 1 ##1 1
                               |-> s_q.pin2[`HPI_PIN_CSN] == 1'b0)
    else $error("pin not seen after two stages");
  cpu_wait_a: assert property (CPU_WAIT_O && DMA_ACK_I |=> !CPU_WAIT_O)
    else $error("processor held past host DMA");
  host_set_a: assert property (s_ctl_wr ##0 pd[`HPI_CTL_DSPI] |=> CPU_INT_O)
    else $error("host write did not raise processor flag");
  data_keep_a: assert property (REG_WR_I && REG_ADDR_I == `HPI_RA_BSC
                                |=> DATA_KEEPER_O == $past(REG_WDATA_I[`HPI_BSC_BH]))
    else $error("data keeper not following bit");
  addr_keep_a: assert property (ADDR_KEEPER_O
                                |-> HOST_KEEPER_O && $past(WIDE_HOST_STRAP_I, 2))
    else $error("address keeper on without strap");
  host_keep_a: assert property ($past(WIDE_HOST_STRAP_I, 2) |-> HOST_KEEPER_O)
    else $error("host keeper off in wide mode");
  wide_noctl_a: assert property (s_launch ##0 !REG_WR_I
                                 |=> $stable(CPU_INT_O) && $stable(HOST_INT_N_O))
    else $error("wide access touched control");

endmodule

//--- rtl/hpi_params.svh
// Constants of the host port interface
`ifndef HPI_PARAMS_SVH
`define HPI_PARAMS_SVH
`define HPI_AW       18
`define HPI_DW       16
`define HPI_PW       42
`define HPI_RAW      4
`define HPI_RA_CTL   4'h0
`define HPI_RA_BSC   4'h1
`define HPI_BSC_BH   1
`define HPI_BSC_HBH  2
`define HPI_CTL_DSPI 0
`define HPI_CTL_HSTI 1
`define HPI_SEL_CTL  2'h0
`define HPI_SEL_DINC 2'h1
`define HPI_SEL_ADR  2'h2
`define HPI_SEL_DAT  2'h3
`define HPI_ADR_INC  18'h00001
`define HPI_PIN_STRAP 41
`define HPI_PIN_CSN   40
`define HPI_PIN_STB1N 39
`define HPI_PIN_STB2N 38
`define HPI_PIN_RW    37
`define HPI_PIN_HALF  36
`define HPI_PIN_SEL   35:34
`define HPI_PIN_ADR   33:16
`define HPI_PIN_DAT   15:0
`endif

//--- rtl/hpi_pkg.sv
// Types of the host port interface
`include "hpi_params.svh"
package hpi_pkg;
  typedef enum logic [1:0] {HPI_IDLE, HPI_DMA, HPI_DONE} hpi_state_e;
  typedef struct packed {
    logic [`HPI_PW-1:0] pin1;
    logic [`HPI_PW-1:0] pin2;
    logic               stb_prev;
    hpi_state_e         state;
    logic [`HPI_AW-1:0] addr;
    logic [`HPI_DW-1:0] data;
    logic [7:0]         latch;
    logic [`HPI_DW-1:0] hout;
    logic               oe;
    logic               ready;
    logic               dma_req;
    logic               dma_we;
    logic               inc;
    logic               dsp_int;
    logic               host_int;
    logic               bh;
    logic               host_keeper_enable;
    logic [`HPI_DW-1:0] rdata;
  } hpi_state_s;
endpackage

//--- tb/hpi_host_model.sv
// Host processor model that drives the host port pins
`timescale 1ns/10ps
module hpi_host_model (
  input  wire logic        clk_i,
  input  wire logic        ready_i,
  input  wire logic [15:0] data_i,
  output logic             cs_n_o,
  output logic             stb1_n_o,
  output logic             stb2_n_o,
  output logic             rw_o,
  output logic             half_o,
  output logic [1:0]       sel_o,
  output logic [17:0]      addr_o,
  output logic [15:0]      data_o
);
  logic which = 1'b0;

  // idle pins, bench starts no access in reset
  initial begin
    cs_n_o = 1'b1;
    stb1_n_o = 1'b1;
    stb2_n_o = 1'b1;
    rw_o = 1'b1;
    half_o = 1'b0;
    sel_o = 2'h0;
    addr_o = 18'h0;
    data_o = 16'h0;
  end

  task xfer(input logic r, input logic h, input logic [1:0] s, input logic [17:0] a,
            input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    stb1_n_o <= which;
    stb2_n_o <= ~which;
    which = ~which;
    rw_o <= r;
    half_o <= h;
    sel_o <= s;
    addr_o <= a;
    data_o <= r ? ~data_o : d;
    repeat (5) @(posedge clk_i);
    n = 0;
    while (ready_i !== 1'b1 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    tb_top.chk(ready_i, 1'b1, "host ready wait");
    q = data_i;
    cs_n_o <= 1'b1;
    stb1_n_o <= 1'b1;
    stb2_n_o <= 1'b1;
    addr_o <= ~a; // Released lines show no stale value
    data_o <= ~d;
    repeat (5) @(posedge clk_i);
  endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench of the host port slave
`timescale 1ns/10ps
module tb_top;
  logic CORE_CLK_I = 0, RST_I = 1, WIDE_HOST_STRAP_I = 1, DMA_ACK_I = 0, CPU_MEM_REQ_I = 0;
  logic REG_WR_I = 0, REG_RD_I = 0, HOST_CHIP_SELECT_N_I, HOST_STROBE_ONE_N_I, exp_we;
  logic HOST_STROBE_TWO_N_I, HOST_READ_WRITE_I, BYTE_HALF_SELECT_I, HOST_DATA_BUS_OE_O;
  logic HOST_READY_OUT_O, HOST_INT_N_O, CPU_INT_O, DMA_REQ_O, DMA_WE_O, CPU_WAIT_O;
  logic DATA_KEEPER_O, HOST_KEEPER_O, ADDR_KEEPER_O;
  logic [1:0]  HOST_REG_SELECT_I;
  logic [3:0]  REG_ADDR_I = 0;
  logic [17:0] HOST_ADDRESS_BUS_I, DMA_ADDR_O, exp_a, aa [6];
  logic [17:0] CPU_MEM_ADDR_I = 0;
  logic [15:0] HOST_DATA_BUS_I, HOST_DATA_BUS_O, REG_RDATA_O, DMA_WDATA_O, host_d, q, ba;
  logic [15:0] REG_WDATA_I = 0, DMA_RDATA_I = 0, dd [6];
  logic [15:0] mem [262144];
  logic [31:0] rnd = 32'h60, rv;
  int          n_mismatch = 0, n_compared = 0, cyc = 0, dly = 0;

  always #25 CORE_CLK_I = ~CORE_CLK_I;
  // Shared data wire: design drives while its enable is high
  assign HOST_DATA_BUS_I = HOST_DATA_BUS_OE_O ? HOST_DATA_BUS_O : host_d;

  hpi_top u_dut (.CORE_CLK_I, .RST_I, .WIDE_HOST_STRAP_I, .HOST_CHIP_SELECT_N_I,
    .HOST_STROBE_ONE_N_I, .HOST_STROBE_TWO_N_I, .HOST_READ_WRITE_I, .BYTE_HALF_SELECT_I,
    .HOST_REG_SELECT_I, .HOST_ADDRESS_BUS_I, .HOST_DATA_BUS_I, .HOST_DATA_BUS_O,
    .HOST_DATA_BUS_OE_O, .HOST_READY_OUT_O, .HOST_INT_N_O, .CPU_INT_O, .REG_ADDR_I,
    .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .DMA_REQ_O, .DMA_WE_O, .DMA_ADDR_O,
    .DMA_WDATA_O, .DMA_RDATA_I, .DMA_ACK_I, .CPU_MEM_REQ_I, .CPU_MEM_ADDR_I, .CPU_WAIT_O,
    .DATA_KEEPER_O, .HOST_KEEPER_O, .ADDR_KEEPER_O);

  hpi_host_model u_host (.clk_i(CORE_CLK_I), .ready_i(HOST_READY_OUT_O),
    .data_i(HOST_DATA_BUS_I), .cs_n_o(HOST_CHIP_SELECT_N_I), .stb1_n_o(HOST_STROBE_ONE_N_I),
    .stb2_n_o(HOST_STROBE_TWO_N_I), .rw_o(HOST_READ_WRITE_I), .half_o(BYTE_HALF_SELECT_I),
    .sel_o(HOST_REG_SELECT_I), .addr_o(HOST_ADDRESS_BUS_I), .data_o(host_d));

  function logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction

  task chk(input logic [17:0] got, input logic [17:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CORE_CLK_I);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1'b1;
    @(posedge CORE_CLK_I);
    REG_WR_I <= 1'b0;
  endtask

  task reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge CORE_CLK_I);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge CORE_CLK_I);
    REG_RD_I <= 1'b0;
    @(posedge CORE_CLK_I);
    d = REG_RDATA_O;
  endtask

  task set_mode(input logic m);
    WIDE_HOST_STRAP_I <= m;
    RST_I <= 1'b1;
    repeat (2) @(posedge CORE_CLK_I);
    RST_I <= 1'b0;
    repeat (4) @(posedge CORE_CLK_I);
  endtask

  // One word in byte mode: high half first, then low half
  task bw(input logic r, input logic [1:0] s, input logic [15:0] d, output logic [15:0] o);
    logic [15:0] hi, lo;
    u_host.xfer(r, 1'b0, s, 18'h0, {8'h0, d[15:8]}, hi);
    u_host.xfer(r, 1'b1, s, 18'h0, {8'h0, d[7:0]}, lo);
    o = {hi[7:0], lo[7:0]};
  endtask

  // Cycle ceiling against hangs
  always @(posedge CORE_CLK_I) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      $display("unexpected at %0t: cycle limit reached", $time);
      give_verdict();
    end
  end

  // On-chip memory answering DMA after a random delay
  always @(posedge CORE_CLK_I) begin
    if (DMA_REQ_O === 1'b1 && !DMA_ACK_I && dly == 0) begin
      chk(DMA_ADDR_O, exp_a, "dma address");
      chk(DMA_WE_O, exp_we, "dma direction");
      chk(CPU_WAIT_O, CPU_MEM_REQ_I && CPU_MEM_ADDR_I == exp_a, "processor wait");
      if (DMA_WE_O) mem[DMA_ADDR_O] = DMA_WDATA_O;
      else DMA_RDATA_I <= mem[DMA_ADDR_O];
      DMA_ACK_I <= 1'b1;
      dly = xs() % 4;
    end else begin
      if (DMA_REQ_O === 1'b1 && !DMA_ACK_I) dly--;
      DMA_ACK_I <= 1'b0;
      DMA_RDATA_I <= ~DMA_RDATA_I;
    end
  end

  initial begin
    set_mode(1'b1);
    chk(HOST_READY_OUT_O, 1'b1, "ready at reset");
    chk(HOST_INT_N_O, 1'b1, "host interrupt at reset");
    reg_rd(4'h1, q);
    chk(q, 0, "bank switch reset");
    reg_rd(4'h7, q);
    chk(q, 0, "unmapped read");
    // Keeper enables for every strap and bit setting
    for (int m = 0; m < 2; m++) begin
      set_mode(m[0]);
      for (int b = 0; b < 4; b++) begin
        reg_wr(4'h1, {13'h0, b[1:0], 1'b0});
        @(posedge CORE_CLK_I);
        chk(DATA_KEEPER_O, b[0], "data keeper");
        chk(HOST_KEEPER_O, b[1] | m[0], "host keeper");
        chk(ADDR_KEEPER_O, b[1] & m[0], "address keeper");
        reg_rd(4'h1, q);
        chk(q, {b[1:0], 1'b0}, "bank switch readback");
      end
    end
    // Wide mode: random writes, top address first, processor contending
    CPU_MEM_REQ_I <= 1'b1;
    exp_we = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rv = xs();
      aa[i] = (i == 0) ? 18'h3ffff : rv[17:0];
      dd[i] = rv[31:16];
      exp_a = aa[i];
      CPU_MEM_ADDR_I <= aa[i];
      u_host.xfer(1'b0, 1'b0, 2'h0, aa[i], dd[i], q);
    end
    exp_we = 1'b0;
    for (int i = 0; i < 6; i++) begin
      exp_a = aa[i];
      CPU_MEM_ADDR_I <= aa[i] ^ {17'h0, i[0]}; // Odd words contend elsewhere
      u_host.xfer(1'b1, 1'b0, 2'h0, aa[i], 16'h0, q);
      chk(q, dd[i], "wide read");
    end
    CPU_MEM_REQ_I <= 1'b0;
    // Byte mode: paired halves, autoincrement, then random access
    set_mode(1'b0);
    rv = xs();
    ba = rv[15:0] & 16'h7ff0;
    bw(1'b0, 2'h2, ba, q);
    exp_we = 1'b1;
    for (int i = 0; i < 2; i++) begin
      exp_a = {2'b0, ba + 16'(i)};
      bw(1'b0, 2'h1, dd[i], q);
    end
    bw(1'b0, 2'h2, ba, q);
    exp_we = 1'b0;
    for (int i = 0; i < 2; i++) begin
      exp_a = {2'b0, ba + 16'(i)};
      bw(1'b1, 2'h1, 16'h0, q);
      chk(q, dd[i], "byte read increment");
    end
    bw(1'b0, 2'h2, ba + 16'h1, q);
    exp_a = {2'b0, ba + 16'h1};
    for (int i = 0; i < 2; i++) begin
      bw(1'b1, 2'h3, 16'h0, q);
      chk(q, dd[1], "byte random access");
    end
    bw(1'b1, 2'h2, 16'h0, q);
    chk(q, ba + 16'h1, "address read back");
    // Control flags from both sides
    reg_wr(4'h0, 16'h0002);
    @(posedge CORE_CLK_I);
    chk(HOST_INT_N_O, 1'b0, "host interrupt raised");
    u_host.xfer(1'b1, 1'b1, 2'h0, 18'h0, 16'h0, q);
    chk(q[1:0], 2'b10, "host control read");
    u_host.xfer(1'b0, 1'b1, 2'h0, 18'h0, 16'h0003, q);
    chk(HOST_INT_N_O, 1'b1, "host interrupt cleared");
    chk(CPU_INT_O, 1'b1, "processor interrupt raised");
    reg_rd(4'h0, q);
    chk(q, 16'h0001, "processor control read");
    reg_wr(4'h0, 16'h0001);
    @(posedge CORE_CLK_I);
    chk(CPU_INT_O, 1'b0, "processor interrupt cleared");
    give_verdict();
  end
endmodule
